// File: src/asps_pkg.sv
// Operation
// - standby only after serial clock stays high the full activation time
// - plain standby exit: data ready after 52.51 ms fast, 401.8 ms slow
// - all delays given at 4.9152 MHz; all but the internal oscillator wake-up scale with conversion period
// - calibrated exit runs offset calibration, ready after 103/803 ms
// - first result after calibrated exit is already fully settled
// - power pin low shuts down all converter circuitry
// - entering power-down resets all internal state
// - power-down accepted anytime during readback, even mid-word
// - after power pin rises, wake-up 7.95 us internal, 5.6 ms crystal
// - after final power-up rise, wake-up behaves as from power-down
package asps_pkg;

  // ****************************************
  // timing base
  // ****************************************
  localparam int unsigned SYS_PERIOD_NS = 20;
  localparam int unsigned NOM_CONV_HZ = 4915200;
  localparam int CNT_W = 32;
  localparam int PULSE_W = 6;

  // ****************************************
  // documented times, in ns
  // ****************************************
  localparam int unsigned T_STBY_ACT_FAST_NS = 12460000;
  localparam int unsigned T_STBY_ACT_SLOW_NS = 99960000;
  localparam int unsigned T_RDY_FAST_NS = 52510000;
  localparam int unsigned T_RDY_SLOW_NS = 401800000;
  localparam int unsigned T_CAL_RDY_FAST_NS = 103000000;
  localparam int unsigned T_CAL_RDY_SLOW_NS = 803000000;
  localparam int unsigned T_WAKE_INT_NS = 7950;
  localparam int unsigned T_WAKE_XTAL_NS = 5600000;

  localparam logic [PULSE_W-1:0] CAL_PULSES = 6'h19;
  localparam int unsigned RESULT_BITS = 24;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0;
  localparam logic [PULSE_W-1:0] PULSE_MAX = 6'h3F;

  // ****************************************
  // time to cycles, scaled by conversion period
  // ****************************************
  // round_up for least times, otherwise round down; never below one cycle
  function automatic int unsigned asps_cycles(
    input int unsigned t_ns,
    input int unsigned conv_hz,
    input bit round_up
  );
    longint unsigned num;
    longint unsigned den;
    longint unsigned q;
    num = longint'(t_ns) * longint'(NOM_CONV_HZ);
    den = longint'(conv_hz) * longint'(SYS_PERIOD_NS);
    q = num / den;
    if (round_up && (q * den != num)) begin
      q = q + 1;
    end
    if (q == 0) begin
      q = 1;
    end
    return int'(q[31:0]);
  endfunction : asps_cycles

  localparam int unsigned STBY_ACT_FAST_CYC =
    asps_cycles(T_STBY_ACT_FAST_NS, NOM_CONV_HZ, 1'b1);
  localparam int unsigned STBY_ACT_SLOW_CYC =
    asps_cycles(T_STBY_ACT_SLOW_NS, NOM_CONV_HZ, 1'b1);
  localparam int unsigned RDY_FAST_CYC =
    asps_cycles(T_RDY_FAST_NS, NOM_CONV_HZ, 1'b0);
  localparam int unsigned RDY_SLOW_CYC =
    asps_cycles(T_RDY_SLOW_NS, NOM_CONV_HZ, 1'b0);
  localparam int unsigned CAL_RDY_FAST_CYC =
    asps_cycles(T_CAL_RDY_FAST_NS, NOM_CONV_HZ, 1'b0);
  localparam int unsigned CAL_RDY_SLOW_CYC =
    asps_cycles(T_CAL_RDY_SLOW_NS, NOM_CONV_HZ, 1'b0);
  // internal oscillator wake-up does not scale with the conversion clock
  localparam int unsigned WAKE_INT_CYC =
    asps_cycles(T_WAKE_INT_NS, NOM_CONV_HZ, 1'b1);
  localparam int unsigned WAKE_XTAL_CYC =
    asps_cycles(T_WAKE_XTAL_NS, NOM_CONV_HZ, 1'b1);

  typedef enum logic [2:0] {
    ASPS_DOWN,
    ASPS_WAKE,
    ASPS_SETTLE,
    ASPS_READY,
    ASPS_STANDBY
  } asps_state_t;

endpackage : asps_pkg

// File: src/asps_sync.sv
`timescale 1ns/1ps
module asps_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : asps_sync

// File: src/asps_sequencer.sv
`timescale 1ns/1ps
module asps_sequencer
  import asps_pkg::*;
#(
  parameter int unsigned CONV_HZ = NOM_CONV_HZ,
  parameter int unsigned STBY_ACT_FAST = STBY_ACT_FAST_CYC,
  parameter int unsigned STBY_ACT_SLOW = STBY_ACT_SLOW_CYC,
  parameter int unsigned RDY_FAST = RDY_FAST_CYC,
  parameter int unsigned RDY_SLOW = RDY_SLOW_CYC,
  parameter int unsigned CAL_RDY_FAST = CAL_RDY_FAST_CYC,
  parameter int unsigned CAL_RDY_SLOW = CAL_RDY_SLOW_CYC,
  parameter int unsigned WAKE_XTAL = WAKE_XTAL_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_clk,
  input wire logic power_down_n,
  input wire logic speed_fast,
  input wire logic clk_is_xtal,
  input wire logic result_bit,
  output logic ready_and_serial_out,
  output logic converter_enable,
  output logic core_reset,
  output logic offset_cal,
  output logic standby,
  output logic result_settled
);

  // ****************************************
  // limits scaled to the conversion clock, internal wake-up excepted
  // ****************************************
  // counts below are given at the nominal rate; a slower conversion
  // clock stretches every scaled delay in proportion
  function automatic logic [CNT_W-1:0] scale(input int unsigned cyc);
    longint unsigned v;
    v = (longint'(cyc) * longint'(NOM_CONV_HZ)) / longint'(CONV_HZ);
    if (v == 0) begin
      v = 1;
    end
    return v[CNT_W-1:0];
  endfunction : scale

  localparam logic [CNT_W-1:0] LIM_ACT_F = scale(STBY_ACT_FAST);
  localparam logic [CNT_W-1:0] LIM_ACT_S = scale(STBY_ACT_SLOW);
  localparam logic [CNT_W-1:0] LIM_RDY_F = scale(RDY_FAST);
  localparam logic [CNT_W-1:0] LIM_RDY_S = scale(RDY_SLOW);
  localparam logic [CNT_W-1:0] LIM_CAL_F = scale(CAL_RDY_FAST);
  localparam logic [CNT_W-1:0] LIM_CAL_S = scale(CAL_RDY_SLOW);
  localparam logic [CNT_W-1:0] LIM_WAKE_X = scale(WAKE_XTAL);
  localparam logic [CNT_W-1:0] LIM_WAKE_I = CNT_W'(WAKE_INT_CYC);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] pins_s;
  logic sclk_s;
  logic pdn_s;
  logic fast_s;
  logic xtal_s;

  asps_sync #(
    .W(4)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({serial_clk, power_down_n, speed_fast, clk_is_xtal}),
    .sync_out(pins_s)
  );

  assign sclk_s = pins_s[3];
  assign pdn_s = pins_s[2];
  assign fast_s = pins_s[1];
  assign xtal_s = pins_s[0];

  // ****************************************
  // sequencer state
  // ****************************************
  asps_state_t state_q;
  asps_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] cnt_inc;
  logic [PULSE_W-1:0] pulse_q;
  logic [PULSE_W-1:0] pulse_d;
  logic cal_q;
  logic cal_d;
  logic shifted_q;
  logic shifted_d;
  logic sclk_prev_q;
  logic sclk_rise;
  logic sclk_fall;
  logic [CNT_W-1:0] lim_act;
  logic [CNT_W-1:0] lim_rdy;
  logic [CNT_W-1:0] lim_wake;

  assign cnt_inc = cnt_q + CNT_ONE;
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;

  always_comb begin
    lim_act = fast_s ? LIM_ACT_F : LIM_ACT_S;
    lim_wake = xtal_s ? LIM_WAKE_X : LIM_WAKE_I;
    if (cal_q) begin
      lim_rdy = fast_s ? LIM_CAL_F : LIM_CAL_S;
    end else begin
      lim_rdy = fast_s ? LIM_RDY_F : LIM_RDY_S;
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    pulse_d = pulse_q;
    cal_d = cal_q;
    shifted_d = shifted_q;
    case (state_q)
      ASPS_DOWN: begin
        cnt_d = CNT_ZERO;
        if (pdn_s) begin
          // every rise, including the last of the power-up toggle
          state_d = ASPS_WAKE;
        end
      end
      ASPS_WAKE: begin
        cnt_d = cnt_inc;
        if (cnt_inc >= lim_wake) begin
          cnt_d = CNT_ZERO;
          state_d = ASPS_SETTLE;
        end
      end
      ASPS_SETTLE: begin
        cnt_d = cnt_inc;
        if (cnt_inc >= lim_rdy) begin
          cnt_d = CNT_ZERO;
          pulse_d = '0;
          shifted_d = 1'b0;
          state_d = ASPS_READY;
        end
      end
      ASPS_READY: begin
        if (sclk_rise) begin
          shifted_d = 1'b1;
        end
        if (sclk_fall && (pulse_q != PULSE_MAX)) begin
          pulse_d = pulse_q + 6'h1;
        end
        if (sclk_s) begin
          cnt_d = cnt_inc;
          if (cnt_inc >= lim_act) begin
            cnt_d = CNT_ZERO;
            // pulses completed before the long high decide calibration
            cal_d = (pulse_q >= CAL_PULSES);
            state_d = ASPS_STANDBY;
          end
        end else begin
          cnt_d = CNT_ZERO;
        end
      end
      ASPS_STANDBY: begin
        cnt_d = CNT_ZERO;
        if (!sclk_s) begin
          state_d = ASPS_SETTLE;
        end
      end
      default: begin
        state_d = ASPS_DOWN;
        cnt_d = CNT_ZERO;
      end
    endcase
    // pin low wins over any state, readback included
    if (!pdn_s) begin
      state_d = ASPS_DOWN;
      cnt_d = CNT_ZERO;
      pulse_d = '0;
      cal_d = 1'b0;
      shifted_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ASPS_DOWN;
      cnt_q <= CNT_ZERO;
      pulse_q <= '0;
      cal_q <= 1'b0;
      shifted_q <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pulse_q <= pulse_d;
      cal_q <= cal_d;
      shifted_q <= shifted_d;
      sclk_prev_q <= sclk_s;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  logic rdy_out_d;
  logic conv_en_d;
  logic core_rst_d;
  logic cal_run_d;
  logic stby_d;
  logic settled_d;

  always_comb begin
    conv_en_d = (state_d != ASPS_DOWN) && (state_d != ASPS_STANDBY);
    core_rst_d = (state_d == ASPS_DOWN);
    cal_run_d = (state_d == ASPS_SETTLE) && cal_d;
    stby_d = (state_d == ASPS_STANDBY);
    // full settle time has passed, calibrated or not
    settled_d = (state_d == ASPS_READY);
    if (state_d == ASPS_READY) begin
      rdy_out_d = shifted_d ? result_bit : 1'b0;
    end else begin
      rdy_out_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready_and_serial_out <= 1'b1;
      converter_enable <= 1'b0;
      core_reset <= 1'b1;
      offset_cal <= 1'b0;
      standby <= 1'b0;
      result_settled <= 1'b0;
    end else begin
      ready_and_serial_out <= rdy_out_d;
      converter_enable <= conv_en_d;
      core_reset <= core_rst_d;
      offset_cal <= cal_run_d;
      standby <= stby_d;
      result_settled <= settled_d;
    end
  end

endmodule : asps_sequencer

// File: tb/asps_seq_asserts.sv
`timescale 1ns/1ps
module asps_seq_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_clk,
  input wire logic power_down_n,
  input wire logic speed_fast,
  input wire logic clk_is_xtal,
  input wire logic result_bit,
  input wire logic ready_and_serial_out,
  input wire logic converter_enable,
  input wire logic core_reset,
  input wire logic offset_cal,
  input wire logic standby,
  input wire logic result_settled
);
  // ****************************************
  // pin sequencing checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // two sync flops plus output register, which is fed from the next state
  a_pd_shutdown: assert property (
    $fell(power_down_n) |-> ##[2:4] (core_reset && !converter_enable))
    else $error("no shutdown");
  a_pd_holds: assert property (
    (!power_down_n) [*5] |-> core_reset && ready_and_serial_out)
    else $error("power-down not held");
  a_down_clear: assert property (
    core_reset |-> ready_and_serial_out && !standby && !result_settled)
    else $error("state kept in power-down");
  a_stby_high: assert property (
    $rose(standby) |-> $past(serial_clk, 4) && $past(serial_clk, 40))
    else $error("standby too early");
  a_cal_busy: assert property (
    offset_cal |-> ready_and_serial_out && converter_enable)
    else $error("ready during calibration");
  a_settled_run: assert property (
    result_settled |-> converter_enable && !offset_cal && !standby)
    else $error("settled while idle");
  a_wake_wait: assert property (
    $fell(core_reset) |-> ready_and_serial_out [*8])
    else $error("ready too soon after wake");
  a_stby_exit: assert property (
    $fell(standby) |-> ready_and_serial_out [*8])
    else $error("ready too soon after standby");
  c_standby: cover property ($rose(standby));
  c_cal: cover property ($rose(offset_cal));
  c_settled: cover property ($rose(result_settled));
endmodule : asps_seq_asserts

bind asps_sequencer asps_seq_asserts u_chk (.clk(clk), .rst(rst),
  .serial_clk(serial_clk), .power_down_n(power_down_n),
  .speed_fast(speed_fast), .clk_is_xtal(clk_is_xtal),
  .result_bit(result_bit), .ready_and_serial_out(ready_and_serial_out),
  .converter_enable(converter_enable), .core_reset(core_reset),
  .offset_cal(offset_cal), .standby(standby),
  .result_settled(result_settled));

// File: tb/asps_host_model.sv
`timescale 1ns/1ps
module asps_host_model (
  input wire logic clk,
  output logic serial_clk,
  output logic power_down_n
);
  // ****************************************
  // host pin driver
  // ****************************************
  initial begin
    serial_clk = 1'b0;
    power_down_n = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  // link clock idles low between frames, 160 ns period
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      serial_clk <= 1'b1;
      w(4);
      serial_clk <= 1'b0;
      w(4);
    end
  endtask : pulses
  task automatic hold(input int n);
    serial_clk <= 1'b1;
    w(n);
  endtask : hold
  task automatic rel();
    serial_clk <= 1'b0;
    w(1);
  endtask : rel
  task automatic pin(input logic v, input int n);
    power_down_n <= v;
    w(n);
  endtask : pin
  task automatic power_up();
    pin(1'b0, 510);
    pin(1'b1, 1310);
    pin(1'b0, 1310);
    power_down_n <= 1'b1;
  endtask : power_up
endmodule : asps_host_model

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import asps_pkg::*;
  localparam int unsigned AF = 50, AS = 60, RF = 100, RS = 120;
  localparam int unsigned CS = 180, WX = 40;
  logic clk, rst, speed_fast, clk_is_xtal, result_bit, serial_clk;
  logic power_down_n, ready_and_serial_out, converter_enable;
  logic core_reset, offset_cal, standby, result_settled;
  int fail_count, checks_done, cycles, n;
  asps_host_model host (.clk(clk), .serial_clk(serial_clk),
    .power_down_n(power_down_n));
  asps_sequencer #(.STBY_ACT_FAST(AF), .STBY_ACT_SLOW(AS),
    .RDY_FAST(RF), .RDY_SLOW(RS), .CAL_RDY_FAST(150),
    .CAL_RDY_SLOW(CS), .WAKE_XTAL(WX)) DUT (.clk(clk), .rst(rst),
    .serial_clk(serial_clk), .power_down_n(power_down_n),
    .speed_fast(speed_fast), .clk_is_xtal(clk_is_xtal),
    .result_bit(result_bit), .ready_and_serial_out(ready_and_serial_out),
    .converter_enable(converter_enable), .core_reset(core_reset),
    .offset_cal(offset_cal), .standby(standby),
    .result_settled(result_settled));
  // ****************************************
  // clock, timeout, shared tasks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    result_bit <= ~result_bit;
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  // sampled at negedge, away from the launching edge
  task automatic time_ready();
    n = 0;
    while (ready_and_serial_out !== 1'b0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
  endtask : time_ready
  task automatic in_win(input int lo);
    check(32'(n >= lo && n <= lo + 8), 32'h1);
  endtask : in_win
  task automatic conclude();
    $display("checks %0d fails %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_power_up();
    host.power_up();
    time_ready();
    in_win(WAKE_INT_CYC + RF);
    @(negedge clk);
    check(result_settled, 1'b1);
    @(posedge clk);
    $display("test power_up done");
  endtask : t_power_up
  task automatic t_plain();
    host.hold(AF - 8);
    host.rel();
    check(standby, 1'b0);
    // 24 falling edges in all: one short of calibration
    host.pulses(23);
    host.hold(AF + 8);
    @(negedge clk);
    check(standby, 1'b1);
    @(posedge clk);
    host.rel();
    repeat (8) @(negedge clk);
    check(offset_cal, 1'b0);
    time_ready();
    in_win(RF - 8);
    $display("test plain standby done");
  endtask : t_plain
  task automatic t_cal();
    speed_fast <= 1'b0;
    host.pulses(25);
    host.hold(AS + 8);
    @(negedge clk);
    check(standby, 1'b1);
    @(posedge clk);
    host.rel();
    repeat (8) @(negedge clk);
    check(offset_cal, 1'b1);
    time_ready();
    in_win(CS - 8);
    @(negedge clk);
    check(result_settled, 1'b1);
    @(posedge clk);
    $display("test calibrated standby done");
  endtask : t_cal
  task automatic t_pd();
    clk_is_xtal <= 1'b1;
    host.pulses(25);
    host.hold(3);
    host.pin(1'b0, 1310);
    @(negedge clk);
    check({core_reset, converter_enable}, 2'h2);
    check(ready_and_serial_out, 1'b1);
    // host lets the serial clock idle low again before waking
    @(posedge clk);
    host.rel();
    host.pin(1'b1, 0);
    time_ready();
    in_win(WX + RS);
    $display("test power-down done");
  endtask : t_pd
  initial begin
    rst = 1'b1;
    speed_fast = 1'b1;
    clk_is_xtal = 1'b0;
    result_bit = 1'b0;
    fail_count = 0;
    checks_done = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_power_up();
    t_plain();
    t_cal();
    t_pd();
    conclude();
  end
endmodule : testbench
